// >>> tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import tlc_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, cfgUpd;
  logic [1:0] bresp, rresp;
  logic [7:0] coreStatus = 8'h00;
  tlc_link_cfg_t coreCfg;
  logic [13:0] expCfg = '0;
  logic tg = 1'b0;
  int n_errors = 0, checked = 0;
  int nUpd = 0;
  logic [7:0] rates [3] = '{TLC_RATE_1G62, TLC_RATE_2G7, TLC_RATE_5G4};
  logic [4:0] lanes [3] = '{TLC_LANES_ONE, TLC_LANES_TWO, TLC_LANES_FOUR};
  logic [11:0] offs [5] = '{12'h000, 12'h004, 12'h008, 12'h03c, 12'h040};

  tlc_link_config_regs i_tlc_link_config_regs(.mclk(mclk), .reset_n(reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .coreStatus(coreStatus), .coreCfg(coreCfg), .coreCfgUpdate(cfgUpd));

  initial begin
    forever #50 mclk = ~mclk;
  end

  // Count update pulses: each toggle must give exactly one
  always @(posedge mclk) begin
    if (cfgUpd === 1'b1) nUpd <= nUpd + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Split mode sends the data one cycle after the address
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input bit split = 1'b0);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= !split;
    do @(posedge mclk); while (!(awready && (wready || split)));
    awvalid <= 1'b0;
    if (split) begin
      wvalid <= 1'b1;
      do @(posedge mclk); while (!wready);
    end
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(posedge mclk); while (!bvalid);
    chk({30'h0, bresp}, 32'h0);
    bready <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge mclk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge mclk); while (!rvalid);
    chk(rdata, exp);
    chk({30'h0, rresp}, 32'h0);
    rready <= 1'b0;
  endtask

  // Margin after the response edge, where the core copy already lands
  task automatic settle;
    repeat (2) @(posedge mclk);
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 5; i++) rdc(offs[i], 32'h0);
    chk({18'h0, coreCfg}, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(TLC_OFS_LINK_RATE, {24'hffffff, rates[i]}, 4'hf);
      wr(TLC_OFS_LANES, {27'h7ffffff, lanes[i]}, 4'hf);
      rdc(TLC_OFS_LINK_RATE, {24'h0, rates[i]});
      rdc(TLC_OFS_LANES, {27'h0, lanes[i]});
      chk({18'h0, coreCfg}, {18'h0, expCfg});
      tg = ~tg;
      wr(TLC_OFS_UPDATE_CTRL, {31'h0, tg}, 4'h1);
      settle();
      expCfg = {rates[i], lanes[i], 1'b0};
      chk({18'h0, coreCfg}, {18'h0, expCfg});
    end
    wr(TLC_OFS_LINK_RATE, 32'h06, 4'hf);
    wr(TLC_OFS_UPDATE_CTRL, {31'h0, tg}, 4'h1);
    settle();
    chk({18'h0, coreCfg}, {18'h0, expCfg});
    wr(TLC_OFS_LINK_RATE, 32'h0a, 4'h0);
    rdc(TLC_OFS_LINK_RATE, 32'h06);
    wr(TLC_OFS_FRAMING, 32'hffffffff, 4'hf);
    rdc(TLC_OFS_FRAMING, 32'h1);
    chk({18'h0, coreCfg}, {18'h0, expCfg | 14'h1});
    wr(TLC_OFS_FRAMING, 32'h0, 4'hf, 1'b1);
    settle();
    chk({18'h0, coreCfg}, {18'h0, expCfg});
    wr(12'h100, 32'hffffffff, 4'hf, 1'b1);
    rdc(12'h100, 32'h0);
    coreStatus <= 8'h3c;
    @(posedge mclk);
    rdc(TLC_OFS_STATUS, 32'h3c);
    wr(TLC_OFS_UPDATE_CTRL, {30'h0, 1'b1, tg}, 4'h1);
    coreStatus <= 8'hc3;
    wr(TLC_OFS_STATUS, 32'h0, 4'hf);
    rdc(TLC_OFS_STATUS, 32'h3c);
    rdc(TLC_OFS_UPDATE_CTRL, {30'h0, 1'b1, tg});
    wr(TLC_OFS_UPDATE_CTRL, {31'h0, tg}, 4'h1);
    @(posedge mclk);
    rdc(TLC_OFS_STATUS, 32'hc3);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rdc(TLC_OFS_LINK_RATE, 32'h0);
    chk({18'h0, coreCfg}, 32'h0);
    chk(nUpd, 32'h3);
    give_verdict();
  end

  initial begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire

// >>> tlc_link_config_regs.sv
// Operation
// - Every configuration register is read and written through the AXI4-Lite slave port.
// - All registers live on the bus clock; the core only sees registered copies of them.
// - A single-bit value read while changing returns wholly its old or wholly its new value.
// - While the host holds the lock bit set, the multi-bit status snapshot is frozen.
// - Rate and lane fields reach the core copies only when the host flips the toggle bit.
// - Undefined and reserved bits always read as zero.
// - Every register resets to zero.
// - The link rate field sits in bits 7:0, codes 0x06, 0x0a and 0x14 select the rates.
// - The lane count field sits in bits 4:0 and the host programs only 1, 2 or 4.
// - Framing bit 0 set selects enhanced framing, clear selects normal framing.
`timescale 1ns/10ps
`default_nettype none

module tlc_link_config_regs
  import tlc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [TLC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [TLC_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [TLC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [TLC_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [TLC_STATUS_W-1:0] coreStatus,
  output tlc_link_cfg_t coreCfg,
  output logic coreCfgUpdate
);

  // ----------------------------------------------------------------
  // Write channel: address and data may arrive in either order
  // ----------------------------------------------------------------
  logic awHeld_q;
  logic [TLC_ADDR_W-1:0] awAddr_q;
  logic wHeld_q;
  logic [TLC_DATA_W-1:0] wData_q;
  logic [3:0] wStrb_q;
  logic bValid_q;

  wire logic awTake = s_axi_awvalid && s_axi_awready;
  wire logic wTake = s_axi_wvalid && s_axi_wready;
  wire logic awHave = awHeld_q || s_axi_awvalid;
  wire logic wHave = wHeld_q || s_axi_wvalid;
  wire logic wrFire = awHave && wHave && !bValid_q;
  wire logic [TLC_ADDR_W-1:0] wrAddr = awHeld_q ? awAddr_q : s_axi_awaddr;
  wire logic [TLC_DATA_W-1:0] wrData = wHeld_q ? wData_q : s_axi_wdata;
  wire logic [3:0] wrStrb = wHeld_q ? wStrb_q : s_axi_wstrb;
  // All defined fields live in byte lane 0
  wire logic wrLane0 = wrFire && wrStrb[0];

  assign s_axi_awready = !awHeld_q && !bValid_q;
  assign s_axi_wready = !wHeld_q && !bValid_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = TLC_RESP_OKAY;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      awHeld_q <= 1'b0;
      awAddr_q <= '0;
      wHeld_q <= 1'b0;
      wData_q <= '0;
      wStrb_q <= '0;
      bValid_q <= 1'b0;
    end else begin
      if (wrFire) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
      end else begin
        if (awTake) begin
          awHeld_q <= 1'b1;
          awAddr_q <= s_axi_awaddr;
        end
        if (wTake) begin
          wHeld_q <= 1'b1;
          wData_q <= s_axi_wdata;
          wStrb_q <= s_axi_wstrb;
        end
      end
      if (wrFire) begin
        bValid_q <= 1'b1;
      end else if (s_axi_bready) begin
        bValid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Address decode on the offset only
  // ----------------------------------------------------------------
  // Upper address bits never reach the block, so any base works
  wire logic wrRate = wrLane0 && (wrAddr == TLC_OFS_LINK_RATE);
  wire logic wrLanes = wrLane0 && (wrAddr == TLC_OFS_LANES);
  wire logic wrFraming = wrLane0 && (wrAddr == TLC_OFS_FRAMING);
  wire logic wrCtrl = wrLane0 && (wrAddr == TLC_OFS_UPDATE_CTRL);

  // ----------------------------------------------------------------
  // Host-visible registers
  // ----------------------------------------------------------------
  logic [TLC_RATE_W-1:0] rate_q;
  logic [TLC_LANES_W-1:0] lanes_q;
  logic framing_q;
  logic toggle_q;
  logic lock_q;
  logic [TLC_STATUS_W-1:0] statusSnap_q;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rate_q <= TLC_RATE_RESET;
      lanes_q <= TLC_LANES_RESET;
      framing_q <= 1'b0;
      toggle_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      if (wrRate) begin
        rate_q <= wrData[TLC_RATE_W-1:0];
      end
      if (wrLanes) begin
        // Stored as written; legal values are the host's concern
        lanes_q <= wrData[TLC_LANES_W-1:0];
      end
      if (wrFraming) begin
        framing_q <= wrData[TLC_FRAMING_BIT];
      end
      if (wrCtrl) begin
        toggle_q <= wrData[TLC_CTRL_TOGGLE_BIT];
        lock_q <= wrData[TLC_CTRL_LOCK_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Status snapshot with lock
  // ----------------------------------------------------------------
  // Whole-word freeze keeps a multi-bit read coherent across cycles
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      statusSnap_q <= TLC_STATUS_RESET;
    end else if (!lock_q) begin
      statusSnap_q <= coreStatus;
    end
  end

  // ----------------------------------------------------------------
  // Functional-core copies
  // ----------------------------------------------------------------
  logic toggleSeen_q;
  tlc_link_cfg_t coreCfg_q;
  logic cfgUpdate_q;

  wire logic toggleFlip = toggle_q != toggleSeen_q;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      toggleSeen_q <= 1'b0;
      coreCfg_q <= TLC_CFG_RESET;
      cfgUpdate_q <= 1'b0;
    end else begin
      toggleSeen_q <= toggle_q;
      cfgUpdate_q <= toggleFlip;
      if (toggleFlip) begin
        coreCfg_q.linkRate <= rate_q;
        coreCfg_q.laneCount <= lanes_q;
      end
      // Single bit needs no toggle: it can never be seen half-changed
      coreCfg_q.enhancedFraming <= framing_q;
    end
  end

  assign coreCfg = coreCfg_q;
  assign coreCfgUpdate = cfgUpdate_q;

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic rValid_q;
  logic [TLC_DATA_W-1:0] rData_q;

  wire logic rdRate = s_axi_araddr == TLC_OFS_LINK_RATE;
  wire logic rdLanes = s_axi_araddr == TLC_OFS_LANES;
  wire logic rdFraming = s_axi_araddr == TLC_OFS_FRAMING;
  wire logic rdCtrl = s_axi_araddr == TLC_OFS_UPDATE_CTRL;
  wire logic rdStatus = s_axi_araddr == TLC_OFS_STATUS;
  // Reserved bits and unmapped offsets fall out as zero
  wire logic [TLC_DATA_W-1:0] rdMux =
    ({TLC_DATA_W{rdRate}} & {24'h000000, rate_q}) |
    ({TLC_DATA_W{rdLanes}} & {27'h0000000, lanes_q}) |
    ({TLC_DATA_W{rdFraming}} & {31'h00000000, framing_q}) |
    ({TLC_DATA_W{rdCtrl}} & {30'h00000000, lock_q, toggle_q}) |
    ({TLC_DATA_W{rdStatus}} & {24'h000000, statusSnap_q});

  assign s_axi_arready = !rValid_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = TLC_RESP_OKAY;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rValid_q <= 1'b0;
      rData_q <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_q <= 1'b1;
      rData_q <= rdMux;
    end else if (s_axi_rready) begin
      rValid_q <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// >>> tlc_link_config_regs_chk.sv
`timescale 1ns/10ps
`default_nettype none
module tlc_link_config_regs_chk
  import tlc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [TLC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [TLC_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [TLC_DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire tlc_link_cfg_t coreCfg,
  input wire logic coreCfgUpdate
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------------------------------
  // Handshake and core copy checks
  // ----------------------------------------------------------------
  // Only writes whose two channels meet in one cycle are tracked here
  wire logic wFire = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  wire logic frameWr = wFire && (s_axi_awaddr == TLC_OFS_FRAMING) && s_axi_wstrb[0];
  property p_bAns; wFire |=> s_axi_bvalid && !s_axi_awready; endproperty
  a_bAns: assert property (p_bAns) else $error("write not answered");
  property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bHold: assert property (p_bHold) else $error("bvalid dropped");
  property p_bOk; s_axi_bvalid |-> s_axi_bresp == TLC_RESP_OKAY; endproperty
  a_bOk: assert property (p_bOk) else $error("write response not okay");
  property p_rAns; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rAns: assert property (p_rAns) else $error("read not answered");
  property p_rHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rHold: assert property (p_rHold) else $error("read data not held");
  property p_rsvd; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_frame; frameWr |-> ##2 coreCfg.enhancedFraming == $past(s_axi_wdata[0], 2);
  endproperty
  a_frame: assert property (p_frame) else $error("framing not applied");
  property p_updOne; coreCfgUpdate |=> !coreCfgUpdate; endproperty
  a_updOne: assert property (p_updOne) else $error("update pulse too long");
  // Reset clears the copy without a pulse
  property p_cfgGate; reset_n && $changed(coreCfg[13:1]) |-> coreCfgUpdate; endproperty
  a_cfgGate: assert property (p_cfgGate) else $error("core copy moved alone");
  c_frame: cover property (frameWr);
  c_upd: cover property (coreCfgUpdate);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_split: cover property (s_axi_awvalid && s_axi_awready && !s_axi_wvalid);
endmodule
bind tlc_link_config_regs tlc_link_config_regs_chk i_chk(.mclk(mclk), .reset_n(reset_n),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .coreCfg(coreCfg),
  .coreCfgUpdate(coreCfgUpdate));
`default_nettype wire

// >>> tlc_pkg.sv
package tlc_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int TLC_ADDR_W = 12;
  localparam int TLC_DATA_W = 32;
  localparam logic [1:0] TLC_RESP_OKAY = 2'h0;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] TLC_OFS_LINK_RATE = 12'h000;
  localparam logic [11:0] TLC_OFS_LANES = 12'h004;
  localparam logic [11:0] TLC_OFS_FRAMING = 12'h008;
  localparam logic [11:0] TLC_OFS_UPDATE_CTRL = 12'h03c;
  localparam logic [11:0] TLC_OFS_STATUS = 12'h040;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int TLC_RATE_W = 8;
  localparam int TLC_LANES_W = 5;
  localparam int TLC_STATUS_W = 8;
  localparam int TLC_CTRL_TOGGLE_BIT = 0;
  localparam int TLC_CTRL_LOCK_BIT = 1;
  localparam int TLC_FRAMING_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] TLC_RATE_RESET = 8'h00;
  localparam logic [4:0] TLC_LANES_RESET = 5'h00;
  localparam logic [7:0] TLC_STATUS_RESET = 8'h00;
  localparam logic [7:0] TLC_RATE_1G62 = 8'h06;
  localparam logic [7:0] TLC_RATE_2G7 = 8'h0a;
  localparam logic [7:0] TLC_RATE_5G4 = 8'h14;
  localparam logic [4:0] TLC_LANES_ONE = 5'h01;
  localparam logic [4:0] TLC_LANES_TWO = 5'h02;
  localparam logic [4:0] TLC_LANES_FOUR = 5'h04;

  // ----------------------------------------------------------------
  // Functional-core copy of the link configuration
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] linkRate;
    logic [4:0] laneCount;
    logic enhancedFraming;
  } tlc_link_cfg_t;

  localparam tlc_link_cfg_t TLC_CFG_RESET = '{8'h00, 5'h00, 1'b0};

endpackage
